//--- src/lcm_params.svh
// Constants of the lossless context modeller.
`ifndef LCM_PARAMS_SVH
`define LCM_PARAMS_SVH
`define LCM_AREA_BINS       8'd158
`define LCM_ZERO_GROUPS_END 8'd100
`define LCM_CAT_BASE_SMALL  8'd100
`define LCM_CAT_BASE_LARGE  8'd129
`define LCM_MAG_OFFSET      8'd14
`define LCM_SIGN_OFFSET     8'd1
`define LCM_SIZE_POS_OFFSET 8'd2
`define LCM_SIZE_NEG_OFFSET 8'd3
`define LCM_LEFT_WEIGHT     20
`define LCM_ABOVE_WEIGHT    4
`define LCM_DEF_LOWER       4'h0
`define LCM_DEF_UPPER       4'h1
`define LCM_MIN_PREC        5'h02
`define LCM_MAX_PREC        5'h10
`define LCM_LINE_MAX        64
`define LCM_COL_W           6
`define LCM_FIFO_DEPTH      32
`define LCM_FIRST_CAT_MASK  16'h0002
`endif

//--- src/lcm_pkg.sv
// Types shared by the lossless context modeller.
`include "lcm_params.svh"
package lcm_pkg;
    typedef enum logic [2:0] {CLS_ZERO, CLS_SPOS, CLS_SNEG, CLS_LPOS, CLS_LNEG} lcm_class_t;
    typedef enum logic [2:0] {ST_IDLE, ST_RST, ST_ZERO, ST_SIGN, ST_SIZE, ST_CAT, ST_BITS} lcm_state_t;
    typedef struct packed {
        logic [15:0] sample;
        logic [15:0] prediction;
        logic        line_start;
        logic        restart;
        logic [1:0]  table_sel;
    } lcm_sample_t;
    typedef struct packed {
        logic [15:0] diff;
        logic [15:0] prediction;
    } lcm_recon_in_t;
    typedef struct packed {
        logic       rst_bins;
        logic [1:0] table_sel;
        logic [7:0] bin;
        logic       bit_val;
        logic       last;
    } lcm_token_t;
endpackage : lcm_pkg

//--- src/lcm_top.sv
// Context modeller with decision FIFO and decoder reconstruction path.
// Overview of operation
// - Condition zero, sign and size decisions on the left and above neighbour differences of the component.
// - Sort each neighbour difference into zero, small or large, positive or negative.
// - Two classes give 25 states, each keeping four decision bins.
// - First line after scan start or restart uses zero class above.
// - At every line start the left difference counts as zero.
// - Each statistics area holds 158 contiguous bins.
// - First 100 bins are 25 groups of four picked by the zero base.
// - Zero base is 20 times left class plus 4 times above class.
// - Remaining 58 bins are two sets of 15 category and 14 bit bins.
// - Category base is 100 for zero or small above, 129 for large.
// - Zero at base, sign base+1, size base+2 positive or base+3 negative.
// - Category decision n uses category base plus n minus one, up to +14.
// - Magnitude bits use the bin fourteen above the ending category bin.
// - Bounds default to 0 and 1 and may be loaded from a marker.
// - Every bin is reinitialised at scan start and each restart; here srst queues no bin reset token, only a sample with restart set does.
// - Precision 2 to 16 bits accepted; up to four tables per scan.
// - On restart the decoder resets prediction and statistics like the encoder; the decoder reconstruction path here has no restart input.
// - Decoder adds difference to prediction modulo 2 to the 16.
// - Non-zero point shift multiplies the reconstructed output by 2 to the shift.
// - One sample is the data unit of every control procedure.
// - Initial prediction is 2 to the P-1, reduced by the point shift.
// - Encoder difference is sample minus prediction modulo 2 to the 16.
`timescale 1ns/1ps
`include "lcm_params.svh"

module lcm_fifo #(
    parameter int W = 13,
    parameter int D = 32
) (
    input  wire logic         ref_clk,
    input  wire logic         srst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } lcm_fifo_st_t;
    lcm_fifo_st_t q;
    lcm_fifo_st_t d;
    logic         push;
    logic         pop;

    assign in_ready  = (q.cnt != (AW+1)'(D));
    assign out_valid = (q.cnt != '0);
    assign out_data  = q.mem[q.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = in_data;
            d.wp = (q.wp == AW'(D-1)) ? '0 : AW'(q.wp + 1'b1);
        end
        if (pop) begin
            d.rp = (q.rp == AW'(D-1)) ? '0 : AW'(q.rp + 1'b1);
        end
        d.cnt = (AW+1)'(q.cnt + {AW'(0), push} - {AW'(0), pop});
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    default clocking fcb @(posedge ref_clk); endclocking
    default disable iff (srst);

    chk_fifo_no_overrun: assert property (q.cnt <= (AW+1)'(D))
        else $error("Decision queue over depth.");
    chk_fifo_head_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("Queue head moved while stalled.");
endmodule : lcm_fifo

module lcm_top (
    input  wire logic                 ref_clk,
    input  wire logic                 srst,
    input  wire logic                 in_valid,
    output logic                      in_ready,
    input  wire lcm_pkg::lcm_sample_t in_data,
    input  wire logic                 cond_load,
    input  wire logic [3:0]           cond_lower,
    input  wire logic [3:0]           cond_upper,
    input  wire logic [4:0]           cfg_precision,
    input  wire logic [3:0]           cfg_point_shift,
    input  wire logic                 dec_valid,
    input  wire lcm_pkg::lcm_recon_in_t dec_data,
    output logic                      recon_valid,
    output logic [15:0]               recon_sample,
    output logic [15:0]               init_pred,
    output logic                      pred_reload,
    output logic                      prec_error,
    output logic                      out_valid,
    input  wire logic                 out_ready,
    output lcm_pkg::lcm_token_t       out_token
);
    typedef struct packed {
        lcm_pkg::lcm_state_t                  st;
        logic [15:0]                          sz;
        logic [15:0]                          mask;
        logic [7:0]                           zbase;
        logic [7:0]                           cbase;
        logic [7:0]                           ctx;
        logic                                 neg;
        logic                                 nonzero;
        logic [1:0]                           table_sel;
        logic [`LCM_COL_W-1:0]                col;
        logic                                 above_ok;
        logic [15:0]                          left;
        logic [3:0]                           bnd_lo;
        logic [3:0]                           bnd_hi;
        logic [`LCM_LINE_MAX-1:0][15:0]       line;
        logic [15:0]                          recon;
        logic                                 recon_v;
        logic [15:0]                          init_pred;
        logic                                 reload;
        logic                                 prec_err;
    } lcm_core_t;

    lcm_core_t           q;
    lcm_core_t           d;
    lcm_pkg::lcm_token_t tok;
    logic                emit;
    logic                fifo_ready;
    logic                push;
    logic                in_fire;

    function automatic lcm_pkg::lcm_class_t lcm_classify(input logic [15:0] diff, input logic [3:0] lo,
                                                         input logic [3:0] hi);
        logic [16:0] mag;
        logic [16:0] tz;
        logic [16:0] ts;
        mag = diff[15] ? {1'b0, 16'(~diff + 16'h0001)} : {1'b0, diff};
        tz  = (17'h00001 << lo) >> 1;
        ts  = 17'h00001 << hi;
        if (mag <= tz) begin
            return lcm_pkg::CLS_ZERO;
        end else if (mag <= ts) begin
            return diff[15] ? lcm_pkg::CLS_SNEG : lcm_pkg::CLS_SPOS;
        end else begin
            return diff[15] ? lcm_pkg::CLS_LNEG : lcm_pkg::CLS_LPOS;
        end
    endfunction : lcm_classify

    function automatic logic [7:0] lcm_zero_base(input lcm_pkg::lcm_class_t lc, input lcm_pkg::lcm_class_t ac);
        return 8'(`LCM_LEFT_WEIGHT * int'(lc) + `LCM_ABOVE_WEIGHT * int'(ac));
    endfunction : lcm_zero_base

    assign in_fire = in_valid && in_ready;
    assign in_ready = (q.st == lcm_pkg::ST_IDLE) && !q.prec_err;
    assign emit = (q.st != lcm_pkg::ST_IDLE);
    assign push = emit && fifo_ready;

    always_comb begin
        tok           = '0;
        tok.table_sel = q.table_sel;
        case (q.st)
            lcm_pkg::ST_RST: begin
                tok.rst_bins = 1'b1;
            end
            lcm_pkg::ST_ZERO: begin
                tok.bin     = q.zbase;
                tok.bit_val = q.nonzero;
                tok.last    = !q.nonzero;
            end
            lcm_pkg::ST_SIGN: begin
                tok.bin     = 8'(q.zbase + `LCM_SIGN_OFFSET);
                tok.bit_val = q.neg;
            end
            lcm_pkg::ST_SIZE: begin
                tok.bin     = 8'(q.zbase + (q.neg ? `LCM_SIZE_NEG_OFFSET : `LCM_SIZE_POS_OFFSET));
                tok.bit_val = (q.sz != 16'h0000);
                tok.last    = (q.sz == 16'h0000);
            end
            lcm_pkg::ST_CAT: begin
                tok.bin     = q.ctx;
                tok.bit_val = (q.sz >= q.mask);
                tok.last    = (q.sz < q.mask) && ((q.mask >> 2) == 16'h0000);
            end
            lcm_pkg::ST_BITS: begin
                tok.bin     = q.ctx;
                tok.bit_val = ((q.sz & q.mask) != 16'h0000);
                tok.last    = (q.mask == 16'h0001);
            end
            default: begin
                tok = '0;
            end
        endcase
    end

    always_comb begin
        logic [15:0]         diff;
        logic [15:0]         above;
        logic [15:0]         leftv;
        logic [15:0]         mag;
        logic [`LCM_COL_W-1:0] col;
        logic                above_on;
        lcm_pkg::lcm_class_t ac;
        diff     = '0;
        above    = '0;
        leftv    = '0;
        mag      = '0;
        col      = '0;
        above_on = 1'b0;
        ac       = lcm_pkg::CLS_ZERO;
        d        = q;
        d.reload = 1'b0;
        if (cond_load) begin
            d.bnd_lo = cond_lower;
            d.bnd_hi = cond_upper;
        end
        d.prec_err  = (cfg_precision < `LCM_MIN_PREC) || (cfg_precision > `LCM_MAX_PREC);
        d.init_pred = 16'((17'h00001 << (cfg_precision - 5'h01)) >> cfg_point_shift);
        d.recon_v   = dec_valid;
        if (dec_valid) begin
            d.recon = 16'(16'(dec_data.prediction + dec_data.diff) << cfg_point_shift);
        end
        if (in_fire) begin
            diff     = 16'(in_data.sample - in_data.prediction);
            col      = in_data.line_start ? '0 : q.col;
            above_on = in_data.restart ? 1'b0 : (in_data.line_start ? 1'b1 : q.above_ok);
            above    = above_on ? q.line[col] : 16'h0000;
            leftv    = in_data.line_start ? 16'h0000 : q.left;
            ac       = lcm_classify(above, q.bnd_lo, q.bnd_hi);
            mag      = diff[15] ? 16'(~diff + 16'h0001) : diff;
            d.zbase  = lcm_zero_base(lcm_classify(leftv, q.bnd_lo, q.bnd_hi), ac);
            d.cbase  = (ac == lcm_pkg::CLS_LPOS || ac == lcm_pkg::CLS_LNEG) ?
                       `LCM_CAT_BASE_LARGE : `LCM_CAT_BASE_SMALL;
            d.neg       = diff[15];
            d.nonzero   = (diff != 16'h0000);
            d.sz        = 16'(mag - 16'h0001);
            d.table_sel = in_data.table_sel;
            d.above_ok  = above_on;
            d.line[col] = diff;
            d.left      = diff;
            d.col       = `LCM_COL_W'(col + 1'b1);
            d.reload    = in_data.restart;
            d.st        = in_data.restart ? lcm_pkg::ST_RST : lcm_pkg::ST_ZERO;
        end else if (push) begin
            case (q.st)
                lcm_pkg::ST_RST: begin
                    d.st = lcm_pkg::ST_ZERO;
                end
                lcm_pkg::ST_ZERO: begin
                    d.st = q.nonzero ? lcm_pkg::ST_SIGN : lcm_pkg::ST_IDLE;
                end
                lcm_pkg::ST_SIGN: begin
                    d.st = lcm_pkg::ST_SIZE;
                end
                lcm_pkg::ST_SIZE: begin
                    d.ctx  = q.cbase;
                    d.mask = `LCM_FIRST_CAT_MASK;
                    d.st   = (q.sz != 16'h0000) ? lcm_pkg::ST_CAT : lcm_pkg::ST_IDLE;
                end
                lcm_pkg::ST_CAT: begin
                    if (q.sz >= q.mask) begin
                        d.ctx  = 8'(q.ctx + 1'b1);
                        d.mask = q.mask << 1;
                    end else begin
                        d.ctx  = 8'(q.ctx + `LCM_MAG_OFFSET);
                        d.mask = q.mask >> 2;
                        d.st   = ((q.mask >> 2) == 16'h0000) ? lcm_pkg::ST_IDLE : lcm_pkg::ST_BITS;
                    end
                end
                lcm_pkg::ST_BITS: begin
                    d.mask = q.mask >> 1;
                    d.st   = (q.mask == 16'h0001) ? lcm_pkg::ST_IDLE : lcm_pkg::ST_BITS;
                end
                default: begin
                    d.st = lcm_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q        <= '0;
            q.st     <= lcm_pkg::ST_IDLE;
            q.bnd_lo <= `LCM_DEF_LOWER;
            q.bnd_hi <= `LCM_DEF_UPPER;
        end else begin
            q <= d;
        end
    end

    lcm_fifo #(
        .W($bits(lcm_pkg::lcm_token_t)),
        .D(`LCM_FIFO_DEPTH)
    ) u_fifo (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .in_valid (emit),
        .in_ready (fifo_ready),
        .in_data  (tok),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data (out_token)
    );

    assign recon_valid  = q.recon_v;
    assign recon_sample = q.recon;
    assign init_pred    = q.init_pred;
    assign pred_reload  = q.reload;
    assign prec_error   = q.prec_err;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    chk_line_left_zero: assert property (in_fire && in_data.line_start |=> q.zbase < 8'd20)
        else $error("Left class not zero at line start.");
    chk_restart_above_zero: assert property (in_fire && in_data.restart |=> q.zbase == 8'd0)
        else $error("Restart sample did not use zero context.");
    chk_reinit_token: assert property (in_fire && in_data.restart |=> q.st == lcm_pkg::ST_RST ##0 tok.rst_bins)
        else $error("Restart did not queue a bin reset.");
    chk_bin_in_area: assert property (push && !tok.rst_bins |-> tok.bin < `LCM_AREA_BINS)
        else $error("Bin index outside statistics area.");
    chk_cat_base_value: assert property (push && q.st == lcm_pkg::ST_SIZE && tok.bit_val
        |=> q.ctx == `LCM_CAT_BASE_SMALL || q.ctx == `LCM_CAT_BASE_LARGE)
        else $error("Category base not 100 or 129.");
    chk_size_bin_sign: assert property (push && q.st == lcm_pkg::ST_SIZE |-> tok.bin[1:0] == {1'b1, q.neg})
        else $error("Size bin does not follow sign.");
    chk_tree_order: assert property (push && q.st == lcm_pkg::ST_ZERO && tok.bit_val |=> q.st == lcm_pkg::ST_SIGN)
        else $error("Sign did not follow non-zero decision.");
    chk_mag_bin_range: assert property (push && q.st == lcm_pkg::ST_BITS
        |-> tok.bin >= 8'(q.cbase + 8'd15) && tok.bin <= 8'(q.cbase + 8'd28))
        else $error("Magnitude bit bin out of range.");
    chk_recon_value: assert property (dec_valid |=> recon_valid
        && recon_sample == 16'(16'($past(dec_data.prediction) + $past(dec_data.diff)) << $past(cfg_point_shift)))
        else $error("Reconstructed sample wrong.");
    chk_prec_refuse: assert property ((cfg_precision < `LCM_MIN_PREC || cfg_precision > `LCM_MAX_PREC)
        |=> prec_error && !in_ready)
        else $error("Sample taken with bad precision.");
    chk_zero_group: assert property (push && q.st == lcm_pkg::ST_ZERO
        |-> tok.bin <= 8'h60 && tok.bin[1:0] == 2'h0)
        else $error("Zero bin not on a group of four.");
    chk_sign_then_size: assert property (push && q.st == lcm_pkg::ST_SIGN |=> q.st == lcm_pkg::ST_SIZE)
        else $error("Size did not follow sign.");
    chk_size_then_cat: assert property (push && q.st == lcm_pkg::ST_SIZE && tok.bit_val
        |=> q.st == lcm_pkg::ST_CAT)
        else $error("Category did not follow size.");
    chk_cat_step: assert property (push && q.st == lcm_pkg::ST_CAT && tok.bit_val
        |=> q.st == lcm_pkg::ST_CAT && q.ctx == 8'($past(q.ctx) + 8'h01))
        else $error("Category bin did not step by one.");
    chk_cat_span: assert property (push && q.st == lcm_pkg::ST_CAT
        |-> tok.bin >= q.cbase && tok.bin <= 8'(q.cbase + 8'h0e))
        else $error("Category bin out of range.");
    chk_bits_same_bin: assert property (push && q.st == lcm_pkg::ST_BITS && !tok.last
        |=> q.st == lcm_pkg::ST_BITS && $stable(tok.bin))
        else $error("Magnitude bits changed bin.");
    chk_restart_reload: assert property (in_fire && in_data.restart |=> pred_reload)
        else $error("Restart did not reload prediction.");
    chk_recon_pulse: assert property (!dec_valid |=> !recon_valid)
        else $error("Reconstruction valid without input.");

    cov_reset_token: cover property (push && tok.rst_bins);
    cov_mag_bits: cover property (push && q.st == lcm_pkg::ST_BITS && tok.last);
    cov_fifo_full: cover property (emit && !fifo_ready);
    cov_large_above: cover property (push && q.st == lcm_pkg::ST_CAT && q.cbase == `LCM_CAT_BASE_LARGE);
    cov_shifted_recon: cover property (recon_valid && cfg_point_shift != 4'h0);
endmodule : lcm_top

//--- testbench/lcm_coder_model.sv
// Behavioural model of the arithmetic coder core that consumes decision tokens.
`timescale 1ns/1ps

module lcm_coder_model (
    input  wire logic                ref_clk,
    input  wire logic                srst,
    input  wire logic [1:0]          pace,
    input  wire logic                out_valid,
    output logic                     out_ready,
    input  wire lcm_pkg::lcm_token_t out_token
);
    lcm_pkg::lcm_token_t tok_q[$];
    int                  bad_bins;
    int                  bin_resets;
    logic                phase;

    initial begin
        out_ready = 1'b0;
        phase = 1'b0;
        bad_bins = 0;
        bin_resets = 0;
    end
    // Ready is prompt, every other cycle, or held low, changed off the sampling edge.
    always @(negedge ref_clk) begin
        phase = ~phase;
        out_ready = !srst && (pace == 2'h0 || (pace == 2'h1 && phase));
    end
    // Tokens are kept in arrival order, which is the decision order.
    always @(posedge ref_clk) begin
        if (!srst && out_valid && out_ready) begin
            tok_q.push_back(out_token);
            if (out_token.bin >= 8'd158) bad_bins++;
            if (out_token.rst_bins) bin_resets++;
        end
    end
endmodule : lcm_coder_model

//--- testbench/lcm_top_test.sv
// Self-checking testbench of the lossless context modeller.
`timescale 1ns/1ps

module lcm_top_test;
    logic                   ref_clk, srst, in_valid, in_ready, cond_load, dec_valid;
    lcm_pkg::lcm_sample_t   in_data;
    logic [3:0]             cond_lower, cond_upper, cfg_point_shift;
    logic [4:0]             cfg_precision;
    lcm_pkg::lcm_recon_in_t dec_data;
    logic                   recon_valid, pred_reload, prec_error, out_valid, out_ready, reload_seen;
    logic [15:0]            recon_sample, init_pred;
    lcm_pkg::lcm_token_t    out_token;
    lcm_pkg::lcm_token_t    exp_q[$];
    logic [1:0]             pace, cur_tbl;
    int                     failures, n_checks;

    lcm_top dut_u (.ref_clk(ref_clk), .srst(srst), .in_valid(in_valid), .in_ready(in_ready),
        .in_data(in_data), .cond_load(cond_load), .cond_lower(cond_lower), .cond_upper(cond_upper),
        .cfg_precision(cfg_precision), .cfg_point_shift(cfg_point_shift), .dec_valid(dec_valid),
        .dec_data(dec_data), .recon_valid(recon_valid), .recon_sample(recon_sample),
        .init_pred(init_pred), .pred_reload(pred_reload), .prec_error(prec_error),
        .out_valid(out_valid), .out_ready(out_ready), .out_token(out_token));
    lcm_coder_model coder_u (.ref_clk(ref_clk), .srst(srst), .pace(pace), .out_valid(out_valid),
        .out_ready(out_ready), .out_token(out_token));

    task automatic wrap_up();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up
    task automatic note_fail(input string msg);
        failures++;
        $display("[FAIL] %0t %s", $time, msg);
    endtask : note_fail
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) note_fail($sformatf("%s got %h exp %h", what, got, exp));
    endtask : chk_val
    task automatic chk_tok(input lcm_pkg::lcm_token_t got, input lcm_pkg::lcm_token_t exp);
        n_checks++;
        if (got !== exp) note_fail($sformatf("token got %h exp %h", got, exp));
    endtask : chk_tok
    task automatic push_tok(input logic rs, input logic [7:0] bin, input logic b);
        exp_q.push_back('{rs, cur_tbl, bin, b, 1'b0});
    endtask : push_tok
    task automatic add_exp(input logic [15:0] v, input logic [7:0] s0, input logic [7:0] x1, input logic rs);
        logic [15:0] sz;
        int          n;
        if (rs) push_tok(1'b1, 8'h00, 1'b0);
        push_tok(1'b0, s0, v != 16'h0000);
        if (v != 16'h0000) begin
            push_tok(1'b0, s0 + 8'h01, v[15]);
            sz = (v[15] ? 16'h0000 - v : v) - 16'h0001;
            push_tok(1'b0, v[15] ? s0 + 8'h03 : s0 + 8'h02, sz != 16'h0000);
            if (sz != 16'h0000) begin
                n = 1;
                while (int'(sz) >= (1 << n)) begin
                    push_tok(1'b0, x1 + 8'(n - 1), 1'b1);
                    n++;
                end
                push_tok(1'b0, x1 + 8'(n - 1), 1'b0);
                for (int k = n - 2; k >= 0; k--) begin
                    push_tok(1'b0, x1 + 8'(n + 13), sz[k]);
                end
            end
        end
        exp_q[exp_q.size() - 1].last = 1'b1;
    endtask : add_exp
    task automatic send_sample(input logic [15:0] smp, input logic [15:0] prd, input logic ls, input logic rs);
        int k;
        k = 0;
        while (in_ready !== 1'b1 && k < 500) begin
            @(negedge ref_clk);
            k++;
        end
        if (k >= 500) note_fail("input wait ran out");
        in_valid = 1'b1;
        in_data = '{smp, prd, ls, rs, cur_tbl};
        @(negedge ref_clk);
        in_valid = 1'b0;
        reload_seen = pred_reload;
    endtask : send_sample
    task automatic collect();
        int k;
        k = 0;
        while (coder_u.tok_q.size() < exp_q.size() && k < 500) begin
            @(negedge ref_clk);
            k++;
        end
        if (k >= 500) note_fail("token wait ran out");
        while (exp_q.size() > 0 && coder_u.tok_q.size() > 0) begin
            chk_tok(coder_u.tok_q.pop_front(), exp_q.pop_front());
        end
        exp_q.delete();
    endtask : collect
    task automatic do_sample(input logic [15:0] smp, input logic [15:0] prd, input logic ls, input logic rs,
                             input logic [7:0] s0, input logic [7:0] x1);
        add_exp(smp - prd, s0, x1, rs);
        send_sample(smp, prd, ls, rs);
        chk_val({15'h0, reload_seen}, {15'h0, rs}, "reload");
        collect();
    endtask : do_sample
    task automatic t_scan_start();
        do_sample(16'h0080, 16'h0080, 1'b1, 1'b1, 8'd0, 8'd100);
        do_sample(16'h0002, 16'hfffd, 1'b0, 1'b0, 8'd0, 8'd100);
        do_sample(16'h0000, 16'h0005, 1'b0, 1'b0, 8'd60, 8'd100);
    endtask : t_scan_start
    task automatic t_second_line();
        do_sample(16'h0011, 16'h0010, 1'b1, 1'b0, 8'd0, 8'd100);
        do_sample(16'h000e, 16'h0010, 1'b0, 1'b0, 8'd32, 8'd129);
        do_sample(16'h0011, 16'h0010, 1'b0, 1'b0, 8'd56, 8'd129);
    endtask : t_second_line
    task automatic t_restart();
        cur_tbl = 2'h3;
        do_sample(16'h0012, 16'h0010, 1'b1, 1'b1, 8'd0, 8'd100);
        do_sample(16'h0010, 16'h0010, 1'b0, 1'b0, 8'd20, 8'd100);
    endtask : t_restart
    task automatic t_bounds();
        cond_lower = 4'h1;
        cond_upper = 4'h3;
        cond_load = 1'b1;
        @(negedge ref_clk);
        cond_load = 1'b0;
        do_sample(16'h0015, 16'h0010, 1'b1, 1'b0, 8'd4, 8'd100);
        do_sample(16'h000f, 16'h0010, 1'b0, 1'b0, 8'd20, 8'd100);
        do_sample(16'h0011, 16'h0010, 1'b1, 1'b0, 8'd4, 8'd100);
        do_sample(16'h0013, 16'h0010, 1'b0, 1'b0, 8'd0, 8'd100);
    endtask : t_bounds
    task automatic t_fifo_full();
        pace = 2'h2;
        add_exp(16'h4000, 8'd0, 8'd100, 1'b1);
        send_sample(16'h4000, 16'h0000, 1'b1, 1'b1);
        add_exp(16'h4000, 8'd60, 8'd100, 1'b0);
        send_sample(16'h4000, 16'h0000, 1'b0, 1'b0);
        repeat (40) @(negedge ref_clk);
        chk_val({15'h0, in_ready}, 16'h0000, "ready while full");
        chk_val({15'h0, out_valid}, 16'h0001, "valid while full");
        pace = 2'h1;
        collect();
        pace = 2'h0;
        repeat (3) @(negedge ref_clk);
        chk_val({15'h0, out_valid}, 16'h0000, "drained");
        chk_val(16'(coder_u.bad_bins), 16'h0000, "bin range");
        chk_val(16'(coder_u.tok_q.size()), 16'h0000, "extra tokens");
        chk_val(16'(coder_u.bin_resets), 16'h0003, "bin resets");
    endtask : t_fifo_full
    task automatic t_decoder();
        dec_valid = 1'b1;
        dec_data = '{16'h0020, 16'hfff0};
        @(negedge ref_clk);
        dec_valid = 1'b0;
        chk_val({15'h0, recon_valid}, 16'h0001, "recon valid");
        chk_val(recon_sample, 16'h0010, "recon wrap");
        @(negedge ref_clk);
        chk_val({15'h0, recon_valid}, 16'h0000, "recon pulse");
        cfg_point_shift = 4'h2;
        dec_valid = 1'b1;
        dec_data = '{16'h1001, 16'h7000};
        @(negedge ref_clk);
        dec_valid = 1'b0;
        chk_val(recon_sample, 16'h0004, "recon shift");
        chk_val(init_pred, 16'h0020, "pred shift");
        cfg_point_shift = 4'h0;
    endtask : t_decoder
    task automatic t_precision();
        logic [4:0]  p[4] = '{5'h01, 5'h11, 5'h02, 5'h10};
        logic [15:0] ip[4] = '{16'h0000, 16'h0000, 16'h0002, 16'h8000};
        for (int i = 0; i < 4; i++) begin
            cfg_precision = p[i];
            repeat (2) @(negedge ref_clk);
            chk_val({15'h0, prec_error}, {15'h0, i < 2}, "precision error");
            chk_val({15'h0, in_ready}, {15'h0, i >= 2}, "ready by precision");
            if (i >= 2) chk_val(init_pred, ip[i], "initial prediction");
        end
        cfg_precision = 5'h08;
        repeat (2) @(negedge ref_clk);
    endtask : t_precision

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        #2000000;
        note_fail("watchdog expired");
        wrap_up();
    end
    initial begin
        {srst, cfg_precision} = {1'b1, 5'h08};
        {in_valid, cond_load, dec_valid, cond_lower, cond_upper, cfg_point_shift} = '0;
        {in_data, dec_data, pace, cur_tbl, reload_seen} = '0;
        failures = 0;
        n_checks = 0;
        repeat (6) @(negedge ref_clk);
        srst = 1'b0;
        @(negedge ref_clk);
        chk_val(init_pred, 16'h0080, "reset prediction");
        t_scan_start();
        t_second_line();
        t_restart();
        t_bounds();
        t_fifo_full();
        t_decoder();
        t_precision();
        wrap_up();
    end
endmodule : lcm_top_test
